//--- msr_monitor_status.sv
// Overview of operation
// [RULE1] Temperature code bits 2:0, resets 000
// [RULE2] I/O supply band code in bits 14:12
// [RULE3] Lower supply bands share one eight-band encoding
// [RULE4] Analog supply band bits 10:8, resets 000
// [RULE5] Start bit self-clears once run begins
// [RULE6] Periodic mode repeats runs, else single run
// [RULE7] Fields update on completion; reserved read zero
`timescale 1ns/100ps
module msr_monitor_status
	import msr_pkg::*;
(
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst_n,
	input  wire logic [MSR_ADDR_W-1:0] i_addr,
	input  wire logic [MSR_DATA_W-1:0] i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [MSR_DATA_W-1:0] o_rdata,
	output logic                       o_meas_req,
	input  wire logic                  i_meas_done,
	input  wire logic [MSR_CODE_W-1:0] i_temp_code,
	input  wire logic [MSR_CODE_W-1:0] i_io_code,
	input  wire logic [MSR_CODE_W-1:0] i_ana_code,
	output logic                       o_irq
);
	logic                   rst_n;
	logic                   periodic_reg;
	logic                   start_reg;
	logic [MSR_CYCLE_W-1:0] cycle_reg;
	logic [MSR_CODE_W-1:0]  temp_reg;
	logic [MSR_CODE_W-1:0]  io_reg;
	logic [MSR_CODE_W-1:0]  ana_reg;
	logic [MSR_IRQ_W-1:0]   irq_stat_reg;
	logic [MSR_IRQ_W-1:0]   irq_stat_next;
	logic [MSR_IRQ_W-1:0]   irq_mask_reg;
	logic [MSR_DATA_W-1:0]  rdata_reg;
	logic [MSR_DATA_W-1:0]  rdata_next;
	logic                   running;
	logic                   running_d_reg;

	wire                    sel_run_cfg   = (i_addr == MSR_OFF_RUN_CFG);
	wire                    sel_cycle     = (i_addr == MSR_OFF_CYCLE_CFG);
	wire                    sel_temp      = (i_addr == MSR_OFF_TEMP_STAT);
	wire                    sel_supply    = (i_addr == MSR_OFF_SUPPLY_STAT);
	wire                    sel_irq_stat  = (i_addr == MSR_OFF_IRQ_STAT);
	wire                    sel_irq_mask  = (i_addr == MSR_OFF_IRQ_MASK);
	wire                    wr_run_cfg    = i_wr && sel_run_cfg;
	wire                    wr_cycle      = i_wr && sel_cycle;
	wire                    wr_irq_stat   = i_wr && sel_irq_stat;
	wire                    wr_irq_mask   = i_wr && sel_irq_mask;
	wire                    run_begun     = running && !running_d_reg;
	wire                    done_evt      = o_meas_req && i_meas_done;
	wire [MSR_IRQ_W-1:0]    irq_evt       = {run_begun, done_evt};

	wire [MSR_DATA_W-1:0]   run_cfg_word  = MSR_DATA_W'({periodic_reg, start_reg});
	wire [MSR_DATA_W-1:0]   cycle_word    = MSR_DATA_W'(cycle_reg);
	wire [MSR_DATA_W-1:0]   temp_word     = MSR_DATA_W'(temp_reg) << MSR_TEMP_LSB; // [RULE1] [RULE7]
	wire [MSR_DATA_W-1:0]   io_word       = MSR_DATA_W'(io_reg) << MSR_IO_LSB; // [RULE2] [RULE3]
	wire [MSR_DATA_W-1:0]   ana_word      = MSR_DATA_W'(ana_reg) << MSR_ANA_LSB; // [RULE4] [RULE3]
	wire [MSR_DATA_W-1:0]   supply_word   = io_word | ana_word; // [RULE7]
	wire [MSR_DATA_W-1:0]   irq_stat_word = MSR_DATA_W'(irq_stat_reg);
	wire [MSR_DATA_W-1:0]   irq_mask_word = MSR_DATA_W'(irq_mask_reg);

	msr_reset_sync u_rst (
		.i_clk   (i_sys_clk),
		.i_rst_n (i_rst_n),
		.o_rst_n (rst_n)
	);

	msr_sequencer u_seq (
		.i_clk       (i_sys_clk),
		.i_rst_n     (rst_n),
		.i_start     (start_reg),
		.i_periodic  (periodic_reg),
		.i_cycle     (cycle_reg),
		.i_meas_done (i_meas_done),
		.o_meas_req  (o_meas_req),
		.o_running   (running)
	);

	// Unmapped addresses read as zero
	always_comb begin
		rdata_next = '0;
		if (sel_run_cfg) begin
			rdata_next = run_cfg_word;
		end else if (sel_cycle) begin
			rdata_next = cycle_word;
		end else if (sel_temp) begin
			rdata_next = temp_word;
		end else if (sel_supply) begin
			rdata_next = supply_word;
		end else if (sel_irq_stat) begin
			rdata_next = irq_stat_word;
		end else if (sel_irq_mask) begin
			rdata_next = irq_mask_word;
		end
	end

	// New events win over a write-one-to-clear in the same cycle
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_irq_stat) begin
			irq_stat_next = irq_stat_reg & ~i_wdata[MSR_IRQ_W-1:0];
		end
		irq_stat_next = irq_stat_next | irq_evt;
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else if (i_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= '0;
		end
	end

	assign o_rdata = rdata_reg;

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			periodic_reg <= MSR_PERIODIC_RST;
			cycle_reg    <= MSR_CYCLE_RST;
			irq_mask_reg <= '0;
		end else begin
			if (wr_run_cfg) begin
				periodic_reg <= i_wdata[MSR_PERIODIC_BIT]; // [RULE6]
			end
			if (wr_cycle) begin
				cycle_reg <= i_wdata[MSR_CYCLE_W-1:0];
			end
			if (wr_irq_mask) begin
				irq_mask_reg <= i_wdata[MSR_IRQ_W-1:0];
			end
		end
	end

	// Start holds until the sequencer leaves idle, then drops by itself
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_reg <= 1'b0;
		end else if (wr_run_cfg && i_wdata[MSR_START_BIT]) begin
			start_reg <= 1'b1; // [RULE5]
		end else if (running) begin
			start_reg <= 1'b0; // [RULE5]
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			running_d_reg <= 1'b0;
			irq_stat_reg  <= '0;
		end else begin
			running_d_reg <= running;
			irq_stat_reg  <= irq_stat_next;
		end
	end

	// Results are captured only at completion, so reads never see a half-updated band
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_reg <= MSR_CODE_RST; // [RULE1]
			io_reg   <= MSR_CODE_RST;
			ana_reg  <= MSR_CODE_RST; // [RULE4]
		end else if (done_evt) begin
			temp_reg <= i_temp_code; // [RULE7]
			io_reg   <= i_io_code; // [RULE2]
			ana_reg  <= i_ana_code; // [RULE4]
		end
	end
endmodule

//--- msr_monitor_status_checker.sv
`timescale 1ns/100ps
module msr_monitor_status_checker
	import msr_pkg::*;
(
	input wire logic                  i_sys_clk,
	input wire logic                  i_rst_n,
	input wire logic [MSR_ADDR_W-1:0] i_addr,
	input wire logic [MSR_DATA_W-1:0] i_wdata,
	input wire logic                  i_wr,
	input wire logic                  i_rd,
	input wire logic [MSR_DATA_W-1:0] o_rdata,
	input wire logic                  o_meas_req,
	input wire logic                  i_meas_done,
	input wire logic [MSR_CODE_W-1:0] i_temp_code,
	input wire logic [MSR_CODE_W-1:0] i_io_code,
	input wire logic [MSR_CODE_W-1:0] i_ana_code,
	input wire logic                  o_irq
);
	logic        rd_reg, t_chk_reg, s_chk_reg, per_reg;
	logic [15:0] exp_reg;
	logic [2:0]  t_reg, io_reg, an_reg;
	logic [3:0]  cyc_reg;
	wire         done_w  = o_meas_req && i_meas_done;
	wire         start_w = i_wr && i_addr == MSR_OFF_RUN_CFG && i_wdata[MSR_START_BIT];
	// Expected read data is frozen at the read edge, so a capture in that same edge cannot skew it
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{rd_reg, t_chk_reg, s_chk_reg, exp_reg, t_reg, io_reg, an_reg, cyc_reg} <= '0;
			per_reg <= 1'b1;
		end else begin
			rd_reg <= i_rd;
			t_chk_reg <= i_rd && i_addr == MSR_OFF_TEMP_STAT;
			s_chk_reg <= i_rd && i_addr == MSR_OFF_SUPPLY_STAT;
			exp_reg <= (i_addr == MSR_OFF_TEMP_STAT) ? {13'h0, t_reg} : {1'b0, io_reg, 1'b0, an_reg, 8'h00};
			if (done_w) {t_reg, io_reg, an_reg} <= {i_temp_code, i_io_code, i_ana_code};
			if (i_wr && i_addr == MSR_OFF_RUN_CFG) per_reg <= i_wdata[MSR_PERIODIC_BIT];
			if (i_wr && i_addr == MSR_OFF_CYCLE_CFG) cyc_reg <= i_wdata[3:0];
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	a_temp_read: assert property (t_chk_reg |-> o_rdata == exp_reg)
		else $error("temperature status read mismatch");
	a_supply_read: assert property (s_chk_reg |-> o_rdata == exp_reg)
		else $error("supply status read mismatch");
	a_rdata_idle: assert property (!rd_reg |-> o_rdata == '0)
		else $error("read data not zero outside read");
	a_start_runs: assert property (start_w && !o_meas_req |-> ##[1:3] o_meas_req)
		else $error("start did not begin a run");
	a_req_holds: assert property (o_meas_req && !i_meas_done |=> o_meas_req)
		else $error("request dropped before done");
	a_single_run: assert property (done_w && !per_reg |=> !o_meas_req [*8])
		else $error("single run repeated");
	a_periodic_rerun: assert property (done_w && per_reg && cyc_reg == 4'h0 |=> !o_meas_req [*8] ##[100:300] o_meas_req)
		else $error("periodic run not repeated");
	c_capture: cover property (done_w);
	c_rerun: cover property (done_w && per_reg ##[100:300] o_meas_req);
	c_irq: cover property ($rose(o_irq));
endmodule
bind msr_monitor_status msr_monitor_status_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_meas_req(o_meas_req),
	.i_meas_done(i_meas_done), .i_temp_code(i_temp_code), .i_io_code(i_io_code), .i_ana_code(i_ana_code),
	.o_irq(o_irq));

//--- msr_monitor_status_tb_top.sv
`timescale 1ns/100ps
module msr_monitor_status_tb_top
	import msr_pkg::*;
;
	`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
	logic        i_sys_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_meas_done = 0, o_meas_req, o_irq;
	logic [10:0] i_addr = '0;
	logic [15:0] i_wdata = '0, o_rdata;
	logic [2:0]  i_temp_code = '0, i_io_code = '0, i_ana_code = '0, t, io, an;
	int          err_total = 0, checked = 0, seed = 32'hd845, gap = 0;
	msr_monitor_status uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_meas_req(o_meas_req), .i_meas_done(i_meas_done),
		.i_temp_code(i_temp_code), .i_io_code(i_io_code), .i_ana_code(i_ana_code), .o_irq(o_irq));
	initial forever #4 i_sys_clk = ~i_sys_clk;
	function automatic logic [15:0] sup(input logic [2:0] a, b);
		return {1'b0, a, 1'b0, b, 8'h00};
	endfunction
	task automatic report_and_stop();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [10:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 0;
	endtask
	task automatic rd(input logic [10:0] a, input logic [15:0] e);
		@(posedge i_sys_clk);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 0;
		#1 `CHK(o_rdata, e)
	endtask
	// Codes are inverted after done so a late capture would show wrong data
	task automatic meas(input logic stop);
		int n;
		n = 0;
		#1;
		while (o_meas_req !== 1'b1 && n < 400) begin @(posedge i_sys_clk); #1 n++; end
		gap = n;
		`CHK(n < 400, 1'b1)
		if (stop) wr(MSR_OFF_RUN_CFG, 16'h0000);
		@(posedge i_sys_clk);
		i_meas_done <= 1;
		{i_temp_code, i_io_code, i_ana_code} <= {t, io, an};
		@(posedge i_sys_clk);
		i_meas_done <= 0;
		{i_temp_code, i_io_code, i_ana_code} <= ~{t, io, an};
	endtask
	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_rst_n <= 1;
		repeat (3) @(posedge i_sys_clk);
		rd(MSR_OFF_TEMP_STAT, 16'h0000);
		rd(MSR_OFF_SUPPLY_STAT, 16'h0000);
		rd(MSR_OFF_RUN_CFG, 16'h0002);
		rd(11'h7ff, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			t = (i < 8) ? 3'(i) : 3'($random(seed));
			io = (i < 8) ? 3'(i) : 3'($random(seed));
			an = (i < 8) ? 3'(7 - i) : 3'($random(seed));
			wr(MSR_OFF_IRQ_MASK, {15'h0, i[0]});
			wr(MSR_OFF_RUN_CFG, 16'h0001);
			meas(1'b0);
			rd(MSR_OFF_TEMP_STAT, {13'h0, t});
			rd(MSR_OFF_SUPPLY_STAT, sup(io, an));
			rd(MSR_OFF_RUN_CFG, 16'h0000);
			rd(MSR_OFF_IRQ_STAT, 16'h0003);
			`CHK(o_irq, i[0])
			wr(MSR_OFF_IRQ_STAT, 16'h0003);
			#1 `CHK(o_irq, 1'b0)
		end
		@(posedge i_sys_clk);
		i_meas_done <= 1;
		@(posedge i_sys_clk);
		i_meas_done <= 0;
		wr(MSR_OFF_TEMP_STAT, 16'hffff);
		wr(MSR_OFF_SUPPLY_STAT, 16'hffff);
		rd(MSR_OFF_TEMP_STAT, {13'h0, t});
		rd(MSR_OFF_SUPPLY_STAT, sup(io, an));
		wr(MSR_OFF_CYCLE_CFG, 16'h0000);
		wr(MSR_OFF_RUN_CFG, 16'h0003);
		meas(1'b0);
		// A new cycle field only takes effect at the next interval load
		wr(MSR_OFF_CYCLE_CFG, 16'h0001);
		rd(MSR_OFF_CYCLE_CFG, 16'h0001);
		meas(1'b0);
		{t, io, an} = 9'($random(seed));
		meas(1'b1);
		`CHK(gap, (MSR_BASE_CYC << 1) + 1)
		rd(MSR_OFF_SUPPLY_STAT, sup(io, an));
		report_and_stop();
	end
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end
endmodule

//--- msr_pkg.sv
package msr_pkg;
	localparam int          MSR_ADDR_W          = 11;
	localparam int          MSR_DATA_W          = 16;
	localparam int          MSR_CODE_W          = 3;
	// Register offsets (word addresses on the management port)
	localparam logic [10:0] MSR_OFF_RUN_CFG     = 11'h481;
	localparam logic [10:0] MSR_OFF_TEMP_STAT   = 11'h483;
	localparam logic [10:0] MSR_OFF_SUPPLY_STAT = 11'h484;
	localparam logic [10:0] MSR_OFF_CYCLE_CFG   = 11'h480;
	localparam logic [10:0] MSR_OFF_IRQ_STAT    = 11'h48a;
	localparam logic [10:0] MSR_OFF_IRQ_MASK    = 11'h48b;
	// Field positions
	localparam int          MSR_START_BIT       = 0;
	localparam int          MSR_PERIODIC_BIT    = 1;
	localparam int          MSR_TEMP_LSB        = 0;
	localparam int          MSR_IO_LSB          = 12;
	localparam int          MSR_ANA_LSB         = 8;
	localparam int          MSR_CYCLE_W         = 4;
	// Reset values
	localparam logic        MSR_PERIODIC_RST    = 1'b1;
	localparam logic [2:0]  MSR_CODE_RST        = 3'h0;
	localparam logic [3:0]  MSR_CYCLE_RST       = 4'h0;
	// Interrupt status bits
	localparam int          MSR_IRQ_DONE_BIT    = 0;
	localparam int          MSR_IRQ_START_BIT   = 1;
	localparam int          MSR_IRQ_W           = 2;
	// Periodic spacing: base time in us, scaled by 2^cycle field
	localparam int          MSR_CLK_MHZ         = 125;
	localparam int          MSR_BASE_US         = 1;
	localparam int          MSR_BASE_CYC        = MSR_BASE_US * MSR_CLK_MHZ;
	localparam int          MSR_WAIT_W          = 24;
endpackage

//--- msr_reset_sync.sv
`timescale 1ns/100ps
module msr_reset_sync (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	output logic      o_rst_n
);
	logic meta_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= 1'b0;
			o_rst_n  <= 1'b0;
		end else begin
			meta_reg <= 1'b1;
			o_rst_n  <= meta_reg;
		end
	end
endmodule

//--- msr_sequencer.sv
`timescale 1ns/100ps
module msr_sequencer
	import msr_pkg::*;
(
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_start,
	input  wire logic                   i_periodic,
	input  wire logic [MSR_CYCLE_W-1:0] i_cycle,
	input  wire logic                   i_meas_done,
	output logic                        o_meas_req,
	output logic                        o_running
);
	typedef enum logic [1:0] {
		MSR_IDLE = 2'b00,
		MSR_MEAS = 2'b01,
		MSR_WAIT = 2'b10
	} msr_state_t;

	msr_state_t            state_reg;
	msr_state_t            state_next;
	logic [MSR_WAIT_W-1:0] wait_reg;
	logic [MSR_WAIT_W-1:0] wait_next;
	wire  [MSR_WAIT_W-1:0] wait_load;

	// Cycle field picks a power-of-two multiple of the base interval
	assign wait_load  = MSR_WAIT_W'(MSR_BASE_CYC) << i_cycle;
	assign o_meas_req = (state_reg == MSR_MEAS);
	assign o_running  = (state_reg != MSR_IDLE);

	always_comb begin
		state_next = state_reg;
		wait_next  = wait_reg;
		case (state_reg)
			MSR_IDLE: begin
				if (i_start) begin
					state_next = MSR_MEAS;
				end
			end
			MSR_MEAS: begin
				if (i_meas_done) begin
					if (i_periodic) begin // [RULE6]
						state_next = MSR_WAIT;
						wait_next  = wait_load;
					end else begin
						state_next = MSR_IDLE;
					end
				end
			end
			MSR_WAIT: begin
				// Clearing periodic mode stops the loop at once, returning to idle without finishing the current interval
				if (!i_periodic) begin
					state_next = MSR_IDLE;
				end else if (wait_reg == '0) begin
					state_next = MSR_MEAS;
				end else begin
					wait_next = wait_reg - 1'b1;
				end
			end
			default: begin
				state_next = MSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= MSR_IDLE;
			wait_reg  <= '0;
		end else begin
			state_reg <= state_next;
			wait_reg  <= wait_next;
		end
	end
endmodule
